// ==== logic/ppsr_pkg.sv ====
// Purpose: Constants of the per-port status and interrupt register set
// Assumes: Registers are 16 bits wide, one per Avalon word, addressed by index
// Notes: Offsets are register indices below the port number nibble
package ppsr_pkg;

	localparam int REG_W = 16;
	localparam int BUS_W = 32;
	localparam int ADDR_W = 16;
	localparam int NUM_EVT = 8;

	// Register indices within a port page; port number is the upper nibble
	localparam logic [11:0] IDX_SYM_ERR = 12'h12a;
	localparam logic [11:0] IDX_INT = 12'h136;
	localparam logic [11:0] IDX_XOVER = 12'h138;
	localparam logic [11:0] IDX_CTRL = 12'h13e;

	// Interrupt register layout
	localparam int INT_EN_LSB = 8;
	localparam int EV_JABBER = 7;
	localparam int EV_RX_ERR = 6;
	localparam int EV_PAGE_RX = 5;
	localparam int EV_PD_FAULT = 4;
	localparam int EV_LP_ACK = 3;
	localparam int EV_LINK_DOWN = 2;
	localparam int EV_REM_FAULT = 1;
	localparam int EV_LINK_UP = 0;

	// Crossover register layout
	localparam int FORCED_WIRING_BIT = 7;
	localparam int XOVER_OFF_BIT = 6;

	// Control register layout
	localparam int JAB_EN_BIT = 9;
	localparam int SPD_1000_BIT = 6;
	localparam int SPD_100_BIT = 5;
	localparam int SPD_10_BIT = 4;
	localparam int DUPLEX_BIT = 3;
	localparam int MASTER_BIT = 2;
	localparam int RSV_RC_BIT = 1;
	localparam logic [15:0] CTRL_WR_MASK = 16'hf382;

	// Reset values and the count saturation limit
	localparam logic [15:0] SYM_ERR_RST = 16'h0000;
	localparam logic [7:0] INT_EN_RST = 8'h00;
	localparam logic [15:0] XOVER_RST = 16'h0000;
	localparam logic [15:0] CTRL_RST = 16'h0300;
	localparam logic [15:0] CNT_MAX = 16'hffff;

endpackage : ppsr_pkg

// ==== logic/ppsr_evt_flag.sv ====
// Purpose: One sticky event flag, set by a pulse, cleared by a register read
// Assumes: Set and clear come from logic on the same clock
// Notes: A set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps
module ppsr_evt_flag (
	input wire logic clock,
	input wire logic nrst,
	input wire logic set,
	input wire logic clr,
	output logic flag_ff
);

	always_ff @(posedge clock) begin
		if (!nrst) begin
			flag_ff <= 1'b0;
		end else if (set) begin
			flag_ff <= 1'b1;
		end else if (clr) begin
			flag_ff <= 1'b0;
		end
	end

	set_wins_a: assert property (@(posedge clock) disable iff (!nrst)
		set |=> flag_ff) else $error("event flag missed a set");

endmodule : ppsr_evt_flag

// ==== logic/ppsr_regs.sv ====
// Purpose: Per-port status, interrupt and crossover registers on an Avalon-MM slave
// Assumes: Event and status inputs come from transceiver logic on the same clock
// Notes: Every access takes two cycles; clear-on-read acts at the first edge
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module ppsr_regs #(
	parameter logic [3:0] PORT_NUM = 4'h1
) (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic receive_symbol_error,
	input wire logic [7:0] event_pulse,
	input wire logic speed_1000,
	input wire logic speed_100,
	input wire logic speed_10,
	input wire logic full_duplex,
	input wire logic gig_master,
	input wire logic auto_wiring_mdi,
	output logic auto_xover_off,
	output logic wiring_mdi,
	output logic jabber_count_en,
	output logic irq
);

	logic ack_ff;
	logic [31:0] rdata_ff;
	logic [15:0] sym_cnt_ff;
	logic [15:0] nxt_sym_cnt;
	logic [7:0] int_en_ff;
	logic [7:0] flags;
	logic [15:0] xover_ff;
	logic [15:0] ctrl_ff;
	logic [15:0] nxt_ctrl;
	logic port_hit;
	logic sel_sym;
	logic sel_int;
	logic sel_xover;
	logic sel_ctrl;
	logic rd_take;
	logic wr_take;
	logic [15:0] wmask;
	logic [15:0] rd_mux;
	logic [15:0] ctrl_view;

	// Address decode on the port page
	assign port_hit = avs_address[15:12] == PORT_NUM;
	assign sel_sym = port_hit && avs_address[11:0] == ppsr_pkg::IDX_SYM_ERR;
	assign sel_int = port_hit && avs_address[11:0] == ppsr_pkg::IDX_INT;
	assign sel_xover = port_hit && avs_address[11:0] == ppsr_pkg::IDX_XOVER;
	assign sel_ctrl = port_hit && avs_address[11:0] == ppsr_pkg::IDX_CTRL;

	// Read side effects at the first edge, write at the second
	assign rd_take = avs_read && !ack_ff;
	assign wr_take = avs_write && ack_ff;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
	assign avs_readdata = rdata_ff;
	assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read || avs_write) && !ack_ff;
		end
	end

	// Status view of the control register
	always_comb begin
		ctrl_view = ctrl_ff;
		ctrl_view[11:10] = 2'h0;
		ctrl_view[0] = 1'b0;
		ctrl_view[ppsr_pkg::SPD_1000_BIT] = speed_1000;
		ctrl_view[ppsr_pkg::SPD_100_BIT] = speed_100;
		ctrl_view[ppsr_pkg::SPD_10_BIT] = speed_10;
		ctrl_view[ppsr_pkg::DUPLEX_BIT] = full_duplex;
		ctrl_view[ppsr_pkg::MASTER_BIT] = gig_master;
	end

	always_comb begin
		rd_mux = 16'h0000;
		if (sel_sym) begin
			rd_mux = sym_cnt_ff;
		end else if (sel_int) begin
			rd_mux = {int_en_ff, flags};
		end else if (sel_xover) begin
			rd_mux = xover_ff;
		end else if (sel_ctrl) begin
			rd_mux = ctrl_view;
		end
	end

	// Unmapped reads return zero
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata_ff <= 32'h0000_0000;
		end else if (rd_take) begin
			rdata_ff <= {16'h0000, rd_mux};
		end
	end

	always_comb begin
		nxt_sym_cnt = sym_cnt_ff;
		if (rd_take && sel_sym) begin
			nxt_sym_cnt = ppsr_pkg::SYM_ERR_RST;
		end
		if (receive_symbol_error && nxt_sym_cnt != ppsr_pkg::CNT_MAX) begin
			nxt_sym_cnt = nxt_sym_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			sym_cnt_ff <= ppsr_pkg::SYM_ERR_RST;
		end else begin
			sym_cnt_ff <= nxt_sym_cnt;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			int_en_ff <= ppsr_pkg::INT_EN_RST;
		end else if (wr_take && sel_int && avs_byteenable[1]) begin
			int_en_ff <= avs_writedata[15:ppsr_pkg::INT_EN_LSB];
		end
	end

	// sticky flags, latched regardless of enables
	genvar gi;
	generate
		for (gi = 0; gi < ppsr_pkg::NUM_EVT; gi++) begin : g_flag
			ppsr_evt_flag u_flag (
				.clock(clock),
				.nrst(nrst),
				.set(event_pulse[gi]),
				.clr(rd_take && sel_int),
				.flag_ff(flags[gi])
			);
		end
	endgenerate

	// level request from flagged and enabled sources
	assign irq = |(flags & int_en_ff);

	// crossover register stores every written bit
	always_ff @(posedge clock) begin
		if (!nrst) begin
			xover_ff <= ppsr_pkg::XOVER_RST;
		end else if (wr_take && sel_xover) begin
			xover_ff <= (xover_ff & ~wmask) | (avs_writedata[15:0] & wmask);
		end
	end

	assign auto_xover_off = xover_ff[ppsr_pkg::XOVER_OFF_BIT];
	// forced mode only while automatic crossover is off
	assign wiring_mdi = auto_xover_off ? xover_ff[ppsr_pkg::FORCED_WIRING_BIT] : auto_wiring_mdi;

	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (rd_take && sel_ctrl) begin
			nxt_ctrl[ppsr_pkg::RSV_RC_BIT] = 1'b0;
		end
		if (wr_take && sel_ctrl) begin
			nxt_ctrl = (ctrl_ff & ~(wmask & ppsr_pkg::CTRL_WR_MASK))
				| (avs_writedata[15:0] & wmask & ppsr_pkg::CTRL_WR_MASK);
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ctrl_ff <= ppsr_pkg::CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	assign jabber_count_en = ctrl_ff[ppsr_pkg::JAB_EN_BIT];

	// Checks on the register behaviour

	// count rises by one per flagged frame
	sym_cnt_inc_a: assert property (@(posedge clock) disable iff (!nrst)
		receive_symbol_error && !rd_take && sym_cnt_ff != ppsr_pkg::CNT_MAX
		|=> sym_cnt_ff == $past(sym_cnt_ff) + 16'h0001)
		else $error("symbol error count did not step");

	// read returns the count then clears it
	sym_cnt_clr_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_sym && !receive_symbol_error
		|=> sym_cnt_ff == 16'h0000 && rdata_ff[15:0] == $past(sym_cnt_ff))
		else $error("symbol error count read not cleared");

	// enables follow a write to the upper byte
	int_en_wr_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_take && sel_int && avs_byteenable[1]
		|=> int_en_ff == $past(avs_writedata[15:8]))
		else $error("interrupt enables not written");

	// enables stay zero until software writes them
	int_en_rst_a: assert property (@(posedge clock)
		!nrst |=> int_en_ff == 8'h00)
		else $error("interrupt enables not zero after reset");

	// a read of the flags clears them unless an event hits
	flag_clr_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_int && event_pulse == 8'h00 |=> flags == 8'h00 ##1 ack_ff == 1'b0)
		else $error("event flags not cleared by read");

	jab_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		event_pulse[ppsr_pkg::EV_JABBER] ##1 !(rd_take && sel_int)
		|=> flags[ppsr_pkg::EV_JABBER])
		else $error("jabber flag lost before read");

	// forced wiring mode drives the output
	wiring_force_a: assert property (@(posedge clock) disable iff (!nrst)
		auto_xover_off |-> wiring_mdi == xover_ff[ppsr_pkg::FORCED_WIRING_BIT])
		else $error("forced wiring mode not applied");

	// forced bit ignored under automatic crossover
	wiring_auto_a: assert property (@(posedge clock) disable iff (!nrst)
		!xover_ff[ppsr_pkg::XOVER_OFF_BIT] |-> wiring_mdi == auto_wiring_mdi)
		else $error("automatic wiring mode overridden");

	// crossover off follows a write of bit 6
	xover_wr_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_take && sel_xover && avs_byteenable[0]
		|=> auto_xover_off == $past(avs_writedata[ppsr_pkg::XOVER_OFF_BIT]))
		else $error("crossover disable not written");

	ctrl_rst_a: assert property (@(posedge clock)
		!nrst |=> ctrl_ff == ppsr_pkg::CTRL_RST && jabber_count_en)
		else $error("control register reset value wrong");

	// jabber counter enable written by software
	jab_en_wr_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_take && sel_ctrl && avs_byteenable[1]
		|=> jabber_count_en == $past(avs_writedata[ppsr_pkg::JAB_EN_BIT]))
		else $error("jabber counter enable not written");

	ctrl_stat_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_ctrl |=> rdata_ff[6] == $past(speed_1000) && rdata_ff[5] == $past(speed_100)
		&& rdata_ff[4] == $past(speed_10) && rdata_ff[3] == $past(full_duplex)
		&& rdata_ff[2] == $past(gig_master))
		else $error("control status bits wrong");

	irq_set_a: assert property (@(posedge clock) disable iff (!nrst)
		(event_pulse & int_en_ff) != 8'h00 && !(wr_take && sel_int) |=> irq)
		else $error("interrupt request not raised");

	en_keep_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_int |=> $stable(int_en_ff))
		else $error("enables changed by read");

	// count holds without an event or a read
	sym_cnt_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		!receive_symbol_error && !(rd_take && sel_sym) |=> $stable(sym_cnt_ff))
		else $error("symbol error count changed unprompted");

	sym_cnt_sat_a: assert property (@(posedge clock) disable iff (!nrst)
		sym_cnt_ff == ppsr_pkg::CNT_MAX && !(rd_take && sel_sym) |=> sym_cnt_ff == ppsr_pkg::CNT_MAX)
		else $error("symbol error count wrapped");

	// enables change only on a write
	int_en_keep_a: assert property (@(posedge clock) disable iff (!nrst)
		!(wr_take && sel_int && avs_byteenable[1]) |=> $stable(int_en_ff))
		else $error("interrupt enables changed without a write");

	flag_rd_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_int |=> rdata_ff[15:0] == {$past(int_en_ff), $past(flags)})
		else $error("interrupt register read data wrong");

	// flags hold without an event or a read
	flag_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		event_pulse == 8'h00 && !(rd_take && sel_int) |=> $stable(flags))
		else $error("event flags changed unprompted");

	// every event latches, enabled or not
	flag_set_a: assert property (@(posedge clock) disable iff (!nrst)
		event_pulse != 8'h00 |=> (flags & $past(event_pulse)) == $past(event_pulse))
		else $error("event flag not latched");

	// request drops once flags are read
	irq_clr_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_int && event_pulse == 8'h00 |=> !irq)
		else $error("interrupt request held after read");

	// crossover register changes only on a write
	xover_keep_a: assert property (@(posedge clock) disable iff (!nrst)
		!(wr_take && sel_xover) |=> $stable(xover_ff))
		else $error("crossover register changed without a write");

	// crossover read returns every stored bit
	xover_rd_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_xover |=> rdata_ff[15:0] == $past(xover_ff))
		else $error("crossover register read data wrong");

	// jabber counter enable changes only on a write
	jab_en_keep_a: assert property (@(posedge clock) disable iff (!nrst)
		!(wr_take && sel_ctrl) |=> $stable(jabber_count_en))
		else $error("jabber counter enable changed without a write");

	ctrl_rsv_wr_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_take && sel_ctrl && avs_byteenable[1] && avs_byteenable[0]
		|=> ctrl_ff[8:7] == $past(avs_writedata[8:7]))
		else $error("reserved control bits not written");

	// Control bit 1 cleared by its read
	ctrl_rc_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_ctrl |=> !ctrl_ff[ppsr_pkg::RSV_RC_BIT])
		else $error("control bit 1 not cleared by read");

	// Unstored control bits 11:10 and 0 read zero
	ctrl_ro_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && sel_ctrl |=> rdata_ff[11:10] == 2'h0 && !rdata_ff[0])
		else $error("unstored control bits not zero");

	// Unmapped reads return zero
	rd_zero_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take && !sel_sym && !sel_int && !sel_xover && !sel_ctrl |=> rdata_ff == 32'h0000_0000)
		else $error("unmapped read not zero");

	// Upper half of read data is always zero
	rd_upper_a: assert property (@(posedge clock) disable iff (!nrst)
		rd_take |=> rdata_ff[31:16] == 16'h0000)
		else $error("upper read data not zero");

	// Writes to another port change nothing
	wr_other_a: assert property (@(posedge clock) disable iff (!nrst)
		wr_take && !port_hit |=> $stable(xover_ff) && $stable(ctrl_ff) && $stable(int_en_ff))
		else $error("write to another port took effect");

	// Bus answer comes one cycle after the request
	bus_ack_a: assert property (@(posedge clock) disable iff (!nrst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held too long");

endmodule : ppsr_regs

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the per-port status and interrupt registers
// Assumes: Port number 1, one wait cycle per access, events only while the bus is idle
// Notes: Random events, enables and control words, with corner cases mixed in
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [15:0] avs_address = 16'h0000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic receive_symbol_error = 1'b0;
	logic [7:0] event_pulse = 8'h00;
	logic speed_1000 = 1'b0;
	logic speed_100 = 1'b0;
	logic speed_10 = 1'b0;
	logic full_duplex = 1'b0;
	logic gig_master = 1'b0;
	logic auto_wiring_mdi = 1'b0;
	logic auto_xover_off;
	logic wiring_mdi;
	logic jabber_count_en;
	logic irq;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	logic [15:0] rdv;
	logic [15:0] x;
	logic [15:0] c;
	logic [7:0] en;
	logic [7:0] ev;
	logic [7:0] ev2;
	int n;
	int unsigned seed_ret;

	always #2.5 clock = ~clock;

	ppsr_regs u_ppsr_regs (
		.clock(clock), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.receive_symbol_error(receive_symbol_error), .event_pulse(event_pulse),
		.speed_1000(speed_1000), .speed_100(speed_100), .speed_10(speed_10),
		.full_duplex(full_duplex), .gig_master(gig_master), .auto_wiring_mdi(auto_wiring_mdi),
		.auto_xover_off(auto_xover_off), .wiring_mdi(wiring_mdi),
		.jabber_count_en(jabber_count_en), .irq(irq)
	);

	function automatic logic [15:0] pa(input logic [11:0] idx);
		return {4'h1, idx};
	endfunction : pa

	// Live status field in bits 6:2
	function automatic logic [15:0] stat();
		return {9'h000, speed_1000, speed_100, speed_10, full_duplex, gig_master, 2'b00};
	endfunction : stat

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wrap_up();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	// Hold request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [15:0] addr, input logic [15:0] wd, output logic [15:0] rd);
		int k;
		k = 0;
		@(posedge clock);
		avs_address <= addr;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {16'h0000, wd};
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) begin
			k++;
			@(posedge clock);
		end
		rd = avs_readdata[15:0];
		chk("wait cycles", k, 1);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rdc(input logic [15:0] addr, input logic [15:0] exp, input string what);
		logic [15:0] d;
		bus(1'b0, addr, 16'h0000, d);
		chk(what, {16'h0000, d}, {16'h0000, exp});
	endtask : rdc

	task automatic wrs(input logic [15:0] addr, input logic [15:0] d);
		bus(1'b1, addr, d, rdv);
		@(posedge clock);
		#1;
	endtask : wrs

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			$display("MISMATCH timeout expected done seen hang");
			wrap_up();
		end
	end

	initial begin
		seed_ret = $urandom(32'h93d4);
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		{speed_1000, speed_100, speed_10, full_duplex, gig_master, auto_wiring_mdi} <= 6'($urandom);
		rdc(pa(ppsr_pkg::IDX_SYM_ERR), 16'h0000, "count reset");
		rdc(pa(ppsr_pkg::IDX_INT), 16'h0000, "int reset");
		rdc(pa(ppsr_pkg::IDX_XOVER), 16'h0000, "xover reset");
		rdc(pa(ppsr_pkg::IDX_CTRL), 16'h0300 | stat(), "ctrl reset");
		chk("jabber enable reset", jabber_count_en, 1'b1);
		chk("wiring reset", wiring_mdi, auto_wiring_mdi);
		for (int r = 0; r < 6; r++) begin
			n = $urandom_range(1, 9);
			repeat (n) begin
				@(posedge clock);
				receive_symbol_error <= 1'b1;
				@(posedge clock);
				receive_symbol_error <= 1'b0;
			end
			rdc(pa(ppsr_pkg::IDX_SYM_ERR), 16'(n), "count");
			rdc(pa(ppsr_pkg::IDX_SYM_ERR), 16'h0000, "count cleared");
			ev = (r == 0) ? 8'h80 : 8'($urandom);
			ev2 = (r == 0) ? 8'h00 : 8'($urandom);
			en = (r == 1) ? 8'hff : 8'($urandom);
			@(posedge clock);
			event_pulse <= ev;
			@(posedge clock);
			event_pulse <= ev2;
			@(posedge clock);
			event_pulse <= 8'h00;
			@(posedge clock);
			#1;
			chk("irq masked", irq, 1'b0);
			wrs(pa(ppsr_pkg::IDX_INT), {en, 8'hff});
			chk("irq", irq, |((ev | ev2) & en));
			rdc(pa(ppsr_pkg::IDX_INT), {en, ev | ev2}, "flags");
			@(posedge clock);
			#1;
			chk("irq cleared", irq, 1'b0);
			rdc(pa(ppsr_pkg::IDX_INT), {en, 8'h00}, "enables kept");
			wrs(pa(ppsr_pkg::IDX_INT), 16'h0000);
			x = 16'($urandom);
			x[6] = r[0];
			wrs(pa(ppsr_pkg::IDX_XOVER), x);
			chk("xover off", auto_xover_off, x[6]);
			chk("wiring", wiring_mdi, x[6] ? x[7] : auto_wiring_mdi);
			rdc(pa(ppsr_pkg::IDX_XOVER), x, "xover readback");
			c = 16'($urandom);
			c[9] = r[1];
			wrs(pa(ppsr_pkg::IDX_CTRL), c);
			chk("jabber enable", jabber_count_en, c[9]);
			rdc(pa(ppsr_pkg::IDX_CTRL), (c & 16'hf382) | stat(), "ctrl");
			{speed_1000, speed_100, speed_10, full_duplex, gig_master} <= 5'(1 << (r % 5));
			@(posedge clock);
			rdc(pa(ppsr_pkg::IDX_CTRL), (c & 16'hf380) | stat(), "ctrl status");
		end
		rdc(pa(12'h130), 16'h0000, "unmapped");
		wrs({4'h2, ppsr_pkg::IDX_XOVER}, 16'hffff);
		rdc(pa(ppsr_pkg::IDX_XOVER), x, "other port ignored");
		avs_byteenable <= 4'h1;
		wrs(pa(ppsr_pkg::IDX_XOVER), 16'hffff);
		avs_byteenable <= 4'hf;
		rdc(pa(ppsr_pkg::IDX_XOVER), {x[15:8], 8'hff}, "byte enable");
		// Reset again in mid-run with every enable set
		wrs(pa(ppsr_pkg::IDX_INT), 16'hff00);
		@(posedge clock);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		rdc(pa(ppsr_pkg::IDX_INT), 16'h0000, "int mid reset");
		chk("irq mid reset", irq, 1'b0);
		rdc(pa(ppsr_pkg::IDX_XOVER), 16'h0000, "xover mid reset");
		rdc(pa(ppsr_pkg::IDX_CTRL), 16'h0300 | stat(), "ctrl mid reset");
		chk("jabber enable mid reset", jabber_count_en, 1'b1);
		wrap_up();
	end
endmodule : tb_top
